// [asp_slot_mapper.sv]
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Line select 0 primary pin, 1 secondary pin
// - TDM slot equals six-bit slot field
// - Other formats: 0-31 left, 32-63 right
// - Fourth resets to 3, third to 2
// - Fifth register at 0x0F, resets to 4
// - Third register at 0x0D, resets to 2
module asp_slot_mapper (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] regPage,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrEn,
  output var logic [7:0] regRdata,
  // Framing and samples
  input wire asp_pkg::asp_fmt_t frameFormat,
  input wire logic [asp_pkg::WORD_BITS-1:0] sampleCh3,
  input wire logic [asp_pkg::WORD_BITS-1:0] sampleCh4,
  input wire logic [asp_pkg::WORD_BITS-1:0] sampleCh5,
  // Serial link pins
  input wire logic bitClk,
  input wire logic frameSync,
  output var logic primaryOut,
  output var logic primaryOutEn_n,
  output var logic secondaryOut,
  output var logic secondaryOutEn_n
);

  logic [asp_pkg::CFG_W-1:0] slotCfg [asp_pkg::NUM_CH];
  logic [asp_pkg::WORD_BITS-1:0] sampleHold [asp_pkg::NUM_CH];
  wire logic [asp_pkg::WORD_BITS-1:0] sampleIn [asp_pkg::NUM_CH];
  wire logic [asp_pkg::NUM_CH-1:0] addrHit;
  wire logic [asp_pkg::NUM_CH-1:0] laneHitP;
  wire logic [asp_pkg::NUM_CH-1:0] laneHitS;
  wire logic [asp_pkg::NUM_CH-1:0] laneBit;
  logic [7:0] next_regRdata;

  logic [1:0] bclkSync;
  logic [1:0] fsSync;
  logic bclkPrev;
  logic fsLast;
  logic [asp_pkg::CNT_W-1:0] bitCnt;
  logic halfRight;
  logic skipBit;
  logic pendRight;
  logic active;

  wire logic pageHit;
  wire logic bclkRise;
  wire logic bclkFall;
  wire logic fsUp;
  wire logic fsDown;
  wire logic drvNow;
  wire logic loadNow;
  logic isTdm;
  logic halfStart;
  logic frameStart;
  logic next_halfRight;
  logic next_skip;

  assign sampleIn[0] = sampleCh3;
  assign sampleIn[1] = sampleCh4;
  assign sampleIn[2] = sampleCh5;
  assign pageHit = (regPage == asp_pkg::REG_PAGE);

  // Configuration registers
  genvar gi;
  generate
    for (gi = 0; gi < asp_pkg::NUM_CH; gi++) begin : g_ch
      assign addrHit[gi] = pageHit && (regAddr == asp_pkg::CH_ADDR[gi]);
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          slotCfg[gi] <= asp_pkg::CH_RESET[gi][asp_pkg::CFG_W-1:0];
        end else if (regWrEn && addrHit[gi]) begin
          slotCfg[gi] <= regWdata[asp_pkg::CFG_W-1:0];
        end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          sampleHold[gi] <= '0;
        end else if (loadNow) begin
          sampleHold[gi] <= sampleIn[gi];
        end
      end
      asp_slot_lane u_lane (
        .slotCfg(slotCfg[gi]),
        .isTdm(isTdm),
        .halfRight(halfRight),
        .bitCnt(bitCnt),
        .sample(sampleHold[gi]),
        .hitPrimary(laneHitP[gi]),
        .hitSecondary(laneHitS[gi]),
        .dataBit(laneBit[gi])
      );
    end
  endgenerate

  // Unmapped addresses read zero
  always_comb begin
    next_regRdata = 8'h00;
    for (int i = 0; i < asp_pkg::NUM_CH; i++) begin
      if (addrHit[i]) begin
        next_regRdata = {1'b0, slotCfg[i]} & asp_pkg::RSVD_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= next_regRdata;
    end
  end

  // Link pins cross in through two flops; edges found on the second
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bclkSync <= 2'h0;
      fsSync <= 2'h0;
      bclkPrev <= 1'b0;
    end else begin
      bclkSync <= {bclkSync[0], bitClk};
      fsSync <= {fsSync[0], frameSync};
      bclkPrev <= bclkSync[1];
    end
  end

  assign bclkRise = bclkSync[1] && !bclkPrev;
  assign bclkFall = !bclkSync[1] && bclkPrev;
  assign fsUp = bclkRise && fsSync[1] && !fsLast;
  assign fsDown = bclkRise && !fsSync[1] && fsLast;

  // Frame sync sampled on bit clock rising edges decides halves
  always_comb begin
    isTdm = 1'b0;
    halfStart = 1'b0;
    frameStart = 1'b0;
    next_halfRight = 1'b0;
    next_skip = 1'b0;
    unique case (frameFormat)
      asp_pkg::FMT_TDM: begin
        isTdm = 1'b1;
        halfStart = fsUp;
        frameStart = fsUp;
      end
      asp_pkg::FMT_I2S: begin
        halfStart = fsUp || fsDown;
        frameStart = fsDown;
        next_halfRight = fsUp;
        next_skip = 1'b1;
      end
      asp_pkg::FMT_LEFT_JUST: begin
        halfStart = fsUp || fsDown;
        frameStart = fsUp;
        next_halfRight = fsDown;
      end
      default: begin
        halfStart = 1'b0;
      end
    endcase
  end

  // I2S data lags its sync edge by one bit clock; the old half keeps its
  // count until the next fall so the last bit of its last slot still goes out
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fsLast <= 1'b0;
      bitCnt <= asp_pkg::CNT_ZERO;
      halfRight <= 1'b0;
      skipBit <= 1'b0;
      pendRight <= 1'b0;
      active <= 1'b0;
    end else if (bclkRise) begin
      fsLast <= fsSync[1];
      skipBit <= halfStart && next_skip;
      pendRight <= next_halfRight;
      if (halfStart && !next_skip) begin
        bitCnt <= asp_pkg::CNT_ZERO;
        halfRight <= next_halfRight;
        active <= 1'b1;
      end
    end else if (bclkFall && skipBit) begin
      skipBit <= 1'b0;
      bitCnt <= asp_pkg::CNT_ZERO;
      halfRight <= pendRight;
      active <= 1'b1;
    end else if (bclkFall && active) begin
      if (bitCnt == asp_pkg::CNT_LAST) begin
        active <= 1'b0;
      end else begin
        bitCnt <= bitCnt + asp_pkg::CNT_ONE;
      end
    end
  end

  // Carried bit only when the old half ended on a slot boundary
  assign drvNow = bclkFall && active
                && (!skipBit || (bitCnt[asp_pkg::POS_W-1:0] == asp_pkg::POS_LAST));
  assign loadNow = (frameStart && !next_skip) || (bclkFall && skipBit && !pendRight);

  // Pins change on bit clock falling edges so the host samples on rising
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      primaryOut <= 1'b0;
      primaryOutEn_n <= 1'b1;
      secondaryOut <= 1'b0;
      secondaryOutEn_n <= 1'b1;
    end else if (drvNow) begin
      primaryOut <= |(laneHitP & laneBit);
      primaryOutEn_n <= ~|laneHitP;
      secondaryOut <= |(laneHitS & laneBit);
      secondaryOutEn_n <= ~|laneHitS;
    end else if (bclkFall) begin
      primaryOut <= 1'b0;
      primaryOutEn_n <= 1'b1;
      secondaryOut <= 1'b0;
      secondaryOutEn_n <= 1'b1;
    end
  end

  // Checks
  logic [asp_pkg::NUM_CH-1:0] written;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      written <= '0;
    end else begin
      written <= written | (addrHit & {asp_pkg::NUM_CH{regWrEn}});
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_line_primary;
    (drvNow && laneHitP[0] && !slotCfg[0][asp_pkg::LINE_BIT])
      |=> !primaryOutEn_n && (primaryOut == $past(laneBit[0]) || $past(laneHitP[1] || laneHitP[2]));
  endproperty
  a_line_primary: assert property (p_line_primary) else $error("primary lane not driven");

  property p_line_secondary;
    (drvNow && laneHitS[1]) |=> !secondaryOutEn_n ##1 $stable(secondaryOutEn_n) [*1];
  endproperty
  a_line_secondary: assert property (p_line_secondary) else $error("secondary lane not driven");

  property p_tdm_slot;
    (drvNow && isTdm && !slotCfg[1][asp_pkg::LINE_BIT]
      && bitCnt[asp_pkg::CNT_W-1:asp_pkg::SLOT_LSB] == slotCfg[1][asp_pkg::SLOT_MSB:0])
      |=> !primaryOutEn_n;
  endproperty
  a_tdm_slot: assert property (p_tdm_slot) else $error("tdm slot missed");

  property p_half_slot;
    (drvNow && !isTdm && !slotCfg[2][asp_pkg::LINE_BIT] && !bitCnt[asp_pkg::CNT_W-1]
      && halfRight == slotCfg[2][asp_pkg::HALF_BIT]
      && bitCnt[asp_pkg::HALF_SLOT_MSB:asp_pkg::SLOT_LSB] == slotCfg[2][asp_pkg::HALF_BIT-1:0])
      |=> !primaryOutEn_n;
  endproperty
  a_half_slot: assert property (p_half_slot) else $error("half slot missed");

  property p_reset_ch4;
    (addrHit[1] && !written[1] && !regWrEn) |=> regRdata == asp_pkg::CH_RESET[1];
  endproperty
  a_reset_ch4: assert property (p_reset_ch4) else $error("fourth channel reset value wrong");

  property p_reset_ch5;
    (addrHit[2] && !written[2] && !regWrEn) |=> regRdata == asp_pkg::CH_RESET[2];
  endproperty
  a_reset_ch5: assert property (p_reset_ch5) else $error("fifth channel reset value wrong");

  property p_reset_ch3;
    (addrHit[0] && !written[0] && !regWrEn) |=> regRdata == asp_pkg::CH_RESET[0];
  endproperty
  a_reset_ch3: assert property (p_reset_ch3) else $error("third channel reset value wrong");

  property p_rsvd_zero;
    (regWrEn && addrHit[0]) ##1 (addrHit[0] && !regWrEn)
      |=> !regRdata[asp_pkg::CFG_W]
        && regRdata[asp_pkg::CFG_W-1:0] == $past(regWdata[asp_pkg::CFG_W-1:0], 2);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit not zero");

  c_tdm_primary: cover property (drvNow && isTdm && |laneHitP);
  c_right_half: cover property (drvNow && !isTdm && halfRight && |laneHitP);
  c_secondary: cover property (drvNow && |laneHitS);
  c_i2s_carry: cover property (drvNow && skipBit && |laneHitP);

endmodule

`default_nettype wire

// [asp_pkg.sv]
package asp_pkg;

  // Register map, page 0 only
  localparam logic [7:0] REG_PAGE = 8'h00;
  localparam int NUM_CH = 3;
  // Index 0 = third channel, 1 = fourth, 2 = fifth
  localparam logic [7:0] CH_ADDR [NUM_CH] = '{8'h0D, 8'h0E, 8'h0F};
  localparam logic [7:0] CH_RESET [NUM_CH] = '{8'h02, 8'h03, 8'h04};

  // Field layout of a channel slot register
  localparam int CFG_W = 7;
  localparam int LINE_BIT = 6;
  localparam int SLOT_MSB = 5;
  localparam int HALF_BIT = 5;
  localparam logic LINE_PRIMARY = 1'b0;
  localparam logic [7:0] RSVD_MASK = 8'h7F;

  // Slot geometry: 64 slots of 32 bit clocks each
  localparam int WORD_BITS = 32;
  localparam int POS_W = 5;
  localparam logic [POS_W-1:0] POS_LAST = 5'h1F;
  localparam int CNT_W = 11;
  localparam int SLOT_LSB = 5;
  localparam int HALF_SLOT_MSB = 9;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [CNT_W-1:0] CNT_LAST = 11'h7FF;

  typedef enum logic [2:0] {
    FMT_TDM = 3'h1,
    FMT_I2S = 3'h2,
    FMT_LEFT_JUST = 3'h4
  } asp_fmt_t;

endpackage

// [asp_slot_lane.sv]
`timescale 1ns/100ps
`default_nettype none

module asp_slot_lane (
  // Channel configuration
  input wire logic [asp_pkg::CFG_W-1:0] slotCfg,
  input wire logic isTdm,
  // Position in the frame
  input wire logic halfRight,
  input wire logic [asp_pkg::CNT_W-1:0] bitCnt,
  // Held sample, MSB first
  input wire logic [asp_pkg::WORD_BITS-1:0] sample,
  // Lane results
  output wire logic hitPrimary,
  output wire logic hitSecondary,
  output wire logic dataBit
);

  wire logic [asp_pkg::SLOT_MSB:0] tdmSlot;
  wire logic [asp_pkg::HALF_SLOT_MSB-asp_pkg::SLOT_LSB:0] halfSlot;
  wire logic [asp_pkg::POS_W-1:0] bitPos;
  wire logic tdmHit;
  wire logic halfHit;
  wire logic slotHit;

  assign tdmSlot = bitCnt[asp_pkg::CNT_W-1:asp_pkg::SLOT_LSB];
  assign halfSlot = bitCnt[asp_pkg::HALF_SLOT_MSB:asp_pkg::SLOT_LSB];
  assign bitPos = bitCnt[asp_pkg::POS_W-1:0];
  assign tdmHit = (tdmSlot == slotCfg[asp_pkg::SLOT_MSB:0]);
  // Upper half of the field picks the right half; only 32 slots per half
  assign halfHit = !bitCnt[asp_pkg::CNT_W-1]
                 && (slotCfg[asp_pkg::HALF_BIT] == halfRight)
                 && (halfSlot == slotCfg[asp_pkg::HALF_BIT-1:0]);
  assign slotHit = isTdm ? tdmHit : halfHit;
  assign hitPrimary = slotHit && (slotCfg[asp_pkg::LINE_BIT] == asp_pkg::LINE_PRIMARY);
  assign hitSecondary = slotHit && (slotCfg[asp_pkg::LINE_BIT] != asp_pkg::LINE_PRIMARY);
  assign dataBit = sample[~bitPos];

endmodule

`default_nettype wire

// [asp_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module asp_host_model (
  // Link clock and framing
  output var logic bitClk,
  output var logic frameSync,
  // Serial data from the device
  input wire logic primaryOut,
  input wire logic primaryOutEn_n,
  input wire logic secondaryOut,
  input wire logic secondaryOutEn_n
);
  logic [0:2048] capP, capPe, capS, capSe;

  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
  end

  // Clock stands still between frames; one lead-in bit sets the old sync level
  task automatic frame(input logic tdm, input logic i2s, input int n);
    int last;
    last = tdm ? n : 2 * n + i2s;
    #3;
    for (int i = -1; i <= last; i++) begin
      if (i < 0) frameSync = i2s;
      else if (tdm) frameSync = (i == 0);
      else frameSync = (i < n) ^ i2s;
      #80 bitClk = 1'b1;
      #80 bitClk = 1'b0;
      // Bit i-1 has settled well before the next falling edge moves it
      if (i > 0) begin
        capP[i-1] = primaryOut;
        capPe[i-1] = primaryOutEn_n;
        capS[i-1] = secondaryOut;
        capSe[i-1] = secondaryOutEn_n;
      end
    end
  endtask
endmodule

`default_nettype wire

// [asp_slot_mapper_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module asp_slot_mapper_tb;
  logic clk_sys, arst_n, regWrEn, bitClk, frameSync;
  logic pOut, pEn_n, sOut, sEn_n;
  logic [7:0] regPage, regAddr, regWdata, regRdata;
  logic [31:0] smp [3];
  asp_pkg::asp_fmt_t frameFormat;
  int cfg [3] = '{2, 3, 4};
  int errors = 0;
  int check_count = 0;
  int seed = 55;
  int cyc = 0;

  asp_slot_mapper i_dut (.clk_sys(clk_sys), .arst_n(arst_n), .regPage(regPage),
    .regAddr(regAddr), .regWdata(regWdata), .regWrEn(regWrEn), .regRdata(regRdata),
    .frameFormat(frameFormat), .sampleCh3(smp[0]), .sampleCh4(smp[1]), .sampleCh5(smp[2]),
    .bitClk(bitClk), .frameSync(frameSync), .primaryOut(pOut), .primaryOutEn_n(pEn_n),
    .secondaryOut(sOut), .secondaryOutEn_n(sEn_n));
  asp_host_model i_host (.bitClk(bitClk), .frameSync(frameSync), .primaryOut(pOut),
    .primaryOutEn_n(pEn_n), .secondaryOut(sOut), .secondaryOutEn_n(sEn_n));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Five frames need about 55k cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    regPage <= pg;
    regAddr <= ad;
    regWdata <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    if (pg == 8'h00 && ad >= 8'h0D && ad <= 8'h0F) cfg[ad - 8'h0D] = d & 8'h7F;
  endtask

  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, input int e);
    @(posedge clk_sys);
    regPage <= pg;
    regAddr <= ad;
    @(posedge clk_sys);
    #1;
    check({24'h0, regRdata}, e[31:0], "register read");
  endtask

  task automatic run_frame(input asp_pkg::asp_fmt_t f, input int n);
    logic [31:0] dp, ep, e;
    logic tdm, i2s, hit, legal;
    int pos;
    legal = f inside {asp_pkg::FMT_TDM, asp_pkg::FMT_I2S, asp_pkg::FMT_LEFT_JUST};
    tdm = (f == asp_pkg::FMT_TDM);
    i2s = (f == asp_pkg::FMT_I2S);
    @(posedge clk_sys);
    frameFormat <= f;
    for (int c = 0; c < 3; c++) smp[c] <= $random(seed);
    @(posedge clk_sys);
    i_host.frame(tdm, i2s, n);
    for (int ln = 0; ln < 2; ln++) begin
      for (int h = 0; h < (tdm ? 1 : 2); h++) begin
        for (int s = 0; s < n / 32; s++) begin
          e = 32'h0;
          hit = 1'b0;
          for (int c = 0; c < 3; c++) begin
            if (legal && cfg[c][6] == ln && (tdm ? cfg[c][5:0] == s :
                cfg[c][5] == h && cfg[c][4:0] == s)) begin
              hit = 1'b1;
              e = e | smp[c];
            end
          end
          // Half formats: right half starts at the sync edge, I2S one bit later
          pos = tdm ? 32 * s : h * n + i2s + 32 * s;
          for (int b = 0; b < 32; b++) begin
            dp[31-b] = ln ? i_host.capS[pos+b] : i_host.capP[pos+b];
            ep[31-b] = ln ? i_host.capSe[pos+b] : i_host.capPe[pos+b];
          end
          check(dp, e, "slot data");
          check(ep, hit ? 32'h0 : 32'hFFFFFFFF, "slot enable");
        end
      end
    end
  endtask

  initial begin
    arst_n = 1'b0;
    regPage = 8'h00;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrEn = 1'b0;
    frameFormat = asp_pkg::FMT_TDM;
    smp = '{default: 32'h0};
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    for (int c = 0; c < 3; c++) rd(8'h00, 8'(13 + c), cfg[c]);
    rd(8'h00, 8'h0C, 0);
    rd(8'h00, 8'h10, 0);
    wr(8'h01, 8'h0D, 8'h55);
    rd(8'h01, 8'h0D, 0);
    rd(8'h00, 8'h0D, 2);
    run_frame(asp_pkg::FMT_TDM, 256);
    wr(8'h00, 8'h0D, 8'h80);
    wr(8'h00, 8'h0E, 8'hFF);
    wr(8'h00, 8'h0F, 8'($random(seed)));
    for (int c = 0; c < 3; c++) rd(8'h00, 8'(13 + c), cfg[c]);
    run_frame(asp_pkg::FMT_TDM, 2048);
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 3; c++) wr(8'h00, 8'(13 + c), 8'($random(seed)));
      run_frame(k ? asp_pkg::FMT_I2S : asp_pkg::FMT_LEFT_JUST, 1024);
    end
    // Undefined framing code: nothing may be driven
    run_frame(asp_pkg::asp_fmt_t'(3'h3), 256);
    finish_test();
  end
endmodule

`default_nettype wire
